/* design/sbsc_consts.svh */
// Offsets, field positions, reset values and counts of the startup controller
`ifndef SBSC_CONSTS_SVH
`define SBSC_CONSTS_SVH
`define SBSC_ADDR_CTRL     12'h000
`define SBSC_ADDR_STATUS   12'h004
`define SBSC_ADDR_INTERVAL 12'h008
`define SBSC_CTRL_RUN      0
`define SBSC_CTRL_RST      1'h0
`define SBSC_STAT_MODE_LSB 0
`define SBSC_STAT_STEP_LSB 2
`define SBSC_STAT_LEAD_LSB 5
`define SBSC_STEP_FIRST    3'h0
`define SBSC_STEP_LAST     3'h5
`define SBSC_PWM_TOP_FAST  8'h7F
`define SBSC_PWM_TOP_SLOW  8'hFF
`define SBSC_DUTY_OFF      7'h00
`define SBSC_LEAD_ZERO     2'h0
`define SBSC_SEEN_MAX      2'h2
`endif

/* design/sbsc_pkg.sv */
// Types shared by the startup controller files
package sbsc_pkg;
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ALIGN  = 2'b01,
      ST_FORCED = 2'b10,
      ST_SENSE  = 2'b11
   } sbsc_mode_t;

   // Bit order of each field: {W, V, U}
   typedef struct packed {
      logic [2:0] hi;
      logic [2:0] lo;
   } sbsc_gate_t;

   typedef struct packed {
      logic forced_rate_sel_hi;
      logic forced_rate_sel_lo;
      logic pwm_rate_sel;
      logic lead_angle_sel_hi;
      logic lead_angle_sel_lo;
      logic position_cmp_pos;
      logic position_cmp_neg;
   } sbsc_pins_t;
endpackage

/* design/sbsc_step_div.sv */
// Forced commutation step divider
`timescale 1ns/1ps
`include "sbsc_consts.svh"
module sbsc_step_div #(
   parameter int W    = 20,
   parameter int BASE = 65536
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         en,
   input  wire logic [1:0]   rate_sel,
   output logic              step_en,
   output logic [W-1:0]      step_len
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic [W-1:0] len_r;
   logic [W-1:0] len_nxt;
   logic         step_r;
   logic         step_nxt;

   // Six steps per forced period: one step lasts BASE << shift cycles
   always_comb begin
      len_nxt  = W'(BASE) << (~rate_sel);
      step_nxt = 1'b0;
      if (!en) begin
         cnt_nxt = '0;
      end else if (cnt_r >= len_r - W'(1)) begin
         cnt_nxt  = '0;
         step_nxt = 1'b1;
      end else begin
         cnt_nxt = cnt_r + W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r  <= '0;
         len_r  <= W'(BASE);
         step_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         len_r  <= len_nxt;
         step_r <= step_nxt;
      end
   end

   assign step_en  = step_r;
   assign step_len = len_r;
endmodule

/* design/sbsc_pwm.sv */
// PWM carrier and duty comparator
`timescale 1ns/1ps
`include "sbsc_consts.svh"
module sbsc_pwm (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       rate_fast,
   input  wire logic [6:0] duty,
   output logic            pwm_on
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic       on_r;
   logic       on_nxt;
   logic [7:0] top;
   logic [6:0] phase;

   always_comb begin
      top     = rate_fast ? `SBSC_PWM_TOP_FAST : `SBSC_PWM_TOP_SLOW;
      cnt_nxt = (cnt_r >= top) ? 8'h00 : cnt_r + 8'h01;
      // 128 duty steps in either period length
      phase   = rate_fast ? cnt_r[6:0] : cnt_r[7:1];
      on_nxt  = phase < duty;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 8'h00;
         on_r  <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         on_r  <= on_nxt;
      end
   end

   assign pwm_on = on_r;
endmodule

/* design/sbsc_top.sv */
// Sensorless brushless startup and commutation control with APB registers
// Summary of operation
// - Forced rate selects H/L, L/H, L/L: step divides by 2^17, 2^18, 2^19.
// - Both forced selects high divide by 2^16; open select counts as low.
// - PWM select high gives period of 128 clocks, low gives 256.
// - Lead selects pick 30, 15, 7.5 or 0 degrees; open reads high.
// - Forced commutation uses zero lead; selected lead only when sensorless.
// - Startup holds windings in fixed DC excitation before forced commutation.
// - Alignment ends when timing input reaches half reference; go forced.
// - During alignment and forced commutation duty follows the soft-start ramp.
// - Rotation faster than forced rate moves control into sensorless mode.
// - Valid back-EMF polarity edges take over commutation timing automatically.
// - Sensorless mode takes duty from the speed command.
// - Speed command is a 7-bit code setting duty in 1/128 steps.
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "sbsc_consts.svh"
module sbsc_top #(
   parameter int STEP_W    = 20,
   parameter int STEP_BASE = 65536
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic [11:0]         paddr,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                forced_rate_sel_hi,
   input  wire logic                forced_rate_sel_lo,
   input  wire logic                pwm_rate_sel,
   input  wire logic                lead_angle_sel_hi,
   input  wire logic                lead_angle_sel_lo,
   input  wire logic                position_cmp_pos,
   input  wire logic                position_cmp_neg,
   input  wire logic                align_timing_input,
   input  wire logic [6:0]          softstart_ramp_input,
   input  wire logic [6:0]          speed_command_input,
   output sbsc_pkg::sbsc_gate_t     gate_out
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   sbsc_pkg::sbsc_pins_t sync1_r;
   sbsc_pkg::sbsc_pins_t pins_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= '0;
         pins_r  <= '0;
      end else begin
         sync1_r <= {forced_rate_sel_hi, forced_rate_sel_lo, pwm_rate_sel,
                     lead_angle_sel_hi, lead_angle_sel_lo,
                     position_cmp_pos, position_cmp_neg};
         pins_r  <= sync1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Functions
   function automatic sbsc_pkg::sbsc_gate_t step_gate(input logic [2:0] s);
      sbsc_pkg::sbsc_gate_t g;
      case (s)
         3'h0: g = '{hi: 3'h1, lo: 3'h2};
         3'h1: g = '{hi: 3'h1, lo: 3'h4};
         3'h2: g = '{hi: 3'h2, lo: 3'h4};
         3'h3: g = '{hi: 3'h2, lo: 3'h1};
         3'h4: g = '{hi: 3'h4, lo: 3'h1};
         3'h5: g = '{hi: 3'h4, lo: 3'h2};
         default: g = '0;
      endcase
      return g;
   endfunction

   // Zero crossing sits 30 degrees before the commutation point of a 60 degree step
   function automatic logic [STEP_W-1:0] lead_delay(input logic [STEP_W-1:0] ivl,
                                                    input logic [1:0] lead);
      logic [STEP_W-1:0] d;
      case (lead)
         2'h3: d = '0;
         2'h2: d = ivl >> 2;
         2'h1: d = (ivl >> 2) + (ivl >> 3);
         2'h0: d = ivl >> 1;
         default: d = '0;
      endcase
      return d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Back-EMF edge timing
   logic              cmp_pos;
   logic              cmp_neg;
   logic              pos_d_r;
   logic              zc;
   logic [STEP_W-1:0] ivl_r;
   logic [STEP_W-1:0] ivl_nxt;
   logic [STEP_W-1:0] last_ivl_r;
   logic [STEP_W-1:0] last_ivl_nxt;
   logic [1:0]        seen_r;
   logic [1:0]        seen_nxt;
   logic [STEP_W-1:0] step_len;
   logic              step_en;
   logic              run;
   sbsc_pkg::sbsc_mode_t mode_r;
   sbsc_pkg::sbsc_mode_t mode_nxt;

   assign cmp_pos = pins_r.position_cmp_pos;
   assign cmp_neg = pins_r.position_cmp_neg;
   // A pos edge only counts while the pair shows opposite polarity
   assign zc = (cmp_pos != pos_d_r) && (cmp_pos != cmp_neg);

   always_comb begin
      ivl_nxt      = (&ivl_r) ? ivl_r : ivl_r + STEP_W'(1);
      last_ivl_nxt = last_ivl_r;
      seen_nxt     = seen_r;
      if (mode_r == sbsc_pkg::ST_IDLE) begin
         seen_nxt = 2'h0;
      end else if (zc) begin
         // Count from one so the register holds the whole edge spacing
         ivl_nxt      = STEP_W'(1);
         last_ivl_nxt = ivl_r;
         if (seen_r != `SBSC_SEEN_MAX) begin
            seen_nxt = seen_r + 2'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_d_r    <= 1'b0;
         ivl_r      <= '0;
         last_ivl_r <= '0;
         seen_r     <= 2'h0;
      end else begin
         pos_d_r    <= cmp_pos;
         ivl_r      <= ivl_nxt;
         last_ivl_r <= last_ivl_nxt;
         seen_r     <= seen_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode sequence and commutation step
   logic [2:0]        step_r;
   logic [2:0]        step_nxt;
   logic [STEP_W-1:0] dly_r;
   logic [STEP_W-1:0] dly_nxt;
   logic              pend_r;
   logic              pend_nxt;
   logic [1:0]        lead_sel;
   logic [1:0]        eff_lead;
   logic              fast_edge;
   logic              advance;

   assign lead_sel  = {pins_r.lead_angle_sel_hi, pins_r.lead_angle_sel_lo};
   // Zero lead until back-EMF timing has taken over
   assign eff_lead  = (mode_r == sbsc_pkg::ST_SENSE) ? lead_sel : `SBSC_LEAD_ZERO;
   // Needs one earlier edge so that the measured interval is real
   assign fast_edge = zc && (seen_r != 2'h0) && (ivl_r < step_len);

   always_comb begin
      mode_nxt = mode_r;
      step_nxt = step_r;
      dly_nxt  = dly_r;
      pend_nxt = pend_r;
      advance  = 1'b0;
      case (mode_r)
         sbsc_pkg::ST_IDLE: begin
            step_nxt = `SBSC_STEP_FIRST;
            pend_nxt = 1'b0;
            if (run) begin
               mode_nxt = sbsc_pkg::ST_ALIGN;
            end
         end
         sbsc_pkg::ST_ALIGN: begin
            step_nxt = `SBSC_STEP_FIRST;
            if (align_timing_input) begin
               mode_nxt = sbsc_pkg::ST_FORCED;
            end
         end
         sbsc_pkg::ST_FORCED: begin
            advance = step_en;
            if (fast_edge) begin
               mode_nxt = sbsc_pkg::ST_SENSE;
               dly_nxt  = lead_delay(ivl_r, lead_sel);
               pend_nxt = 1'b1;
               advance  = 1'b0;
            end
         end
         sbsc_pkg::ST_SENSE: begin
            if (zc) begin
               dly_nxt  = lead_delay(ivl_r, eff_lead);
               pend_nxt = 1'b1;
            end else if (pend_r && dly_r == '0) begin
               pend_nxt = 1'b0;
               advance  = 1'b1;
            end else if (pend_r) begin
               dly_nxt = dly_r - STEP_W'(1);
            end
         end
         default: mode_nxt = sbsc_pkg::ST_IDLE;
      endcase
      if (advance) begin
         step_nxt = (step_r == `SBSC_STEP_LAST) ? `SBSC_STEP_FIRST : step_r + 3'h1;
      end
      if (!run) begin
         mode_nxt = sbsc_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= sbsc_pkg::ST_IDLE;
         step_r <= `SBSC_STEP_FIRST;
         dly_r  <= '0;
         pend_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         step_r <= step_nxt;
         dly_r  <= dly_nxt;
         pend_r <= pend_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Duty, PWM and gate drive
   logic [6:0]           duty;
   logic                 pwm_on;
   sbsc_pkg::sbsc_gate_t gate_r;
   sbsc_pkg::sbsc_gate_t gate_nxt;

   always_comb begin
      case (mode_r)
         sbsc_pkg::ST_ALIGN:  duty = softstart_ramp_input;
         sbsc_pkg::ST_FORCED: duty = softstart_ramp_input;
         sbsc_pkg::ST_SENSE:  duty = speed_command_input;
         default:             duty = `SBSC_DUTY_OFF;
      endcase
      gate_nxt = step_gate(step_r);
      // Chopping acts on the high side only
      gate_nxt.hi = pwm_on ? gate_nxt.hi : 3'h0;
      if (mode_r == sbsc_pkg::ST_IDLE) begin
         gate_nxt = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_r <= '0;
      end else begin
         gate_r <= gate_nxt;
      end
   end

   assign gate_out = gate_r;

   sbsc_step_div #(
      .W    (STEP_W),
      .BASE (STEP_BASE)
   ) u_step_div (
      .pclk     (pclk),
      .presetn  (presetn),
      .en       (mode_r == sbsc_pkg::ST_FORCED),
      .rate_sel ({pins_r.forced_rate_sel_hi, pins_r.forced_rate_sel_lo}),
      .step_en  (step_en),
      .step_len (step_len)
   );

   sbsc_pwm u_pwm (
      .pclk      (pclk),
      .presetn   (presetn),
      .rate_fast (pins_r.pwm_rate_sel),
      .duty      (duty),
      .pwm_on    (pwm_on)
   );

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: one access cycle, data latched in the setup cycle
   logic        run_r;
   logic        run_nxt;
   logic        rdy_r;
   logic        rdy_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        err_r;
   logic        err_nxt;
   logic        hit;
   logic        setup;

   assign setup = psel && !penable;
   assign hit   = (paddr == `SBSC_ADDR_CTRL) || (paddr == `SBSC_ADDR_STATUS) ||
                  (paddr == `SBSC_ADDR_INTERVAL);

   always_comb begin
      run_nxt   = run_r;
      rdy_nxt   = setup;
      rdata_nxt = rdata_r;
      err_nxt   = err_r;
      if (setup) begin
         err_nxt   = !hit;
         rdata_nxt = 32'h0000_0000;
         case (paddr)
            `SBSC_ADDR_CTRL:     rdata_nxt[`SBSC_CTRL_RUN] = run_r;
            `SBSC_ADDR_STATUS: begin
               rdata_nxt[`SBSC_STAT_MODE_LSB +: 2] = mode_r;
               rdata_nxt[`SBSC_STAT_STEP_LSB +: 3] = step_r;
               rdata_nxt[`SBSC_STAT_LEAD_LSB +: 2] = eff_lead;
            end
            `SBSC_ADDR_INTERVAL: rdata_nxt[STEP_W-1:0] = last_ivl_r;
            default:             rdata_nxt = 32'h0000_0000;
         endcase
      end
      if (pready && pwrite && paddr == `SBSC_ADDR_CTRL) begin
         run_nxt = pwdata[`SBSC_CTRL_RUN];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r   <= `SBSC_CTRL_RST;
         rdy_r   <= 1'b0;
         rdata_r <= 32'h0000_0000;
         err_r   <= 1'b0;
      end else begin
         run_r   <= run_nxt;
         rdy_r   <= rdy_nxt;
         rdata_r <= rdata_nxt;
         err_r   <= err_nxt;
      end
   end

   assign run     = run_r;
   assign pready  = psel && penable && rdy_r;
   assign prdata  = rdata_r;
   assign pslverr = pready && err_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_align_before_forced: assert property (
      (mode_r == sbsc_pkg::ST_FORCED && $past(mode_r) != sbsc_pkg::ST_FORCED)
      |-> $past(mode_r) == sbsc_pkg::ST_ALIGN)
      else $error("forced mode entered without alignment");
   a_align_hold_step: assert property (
      mode_r == sbsc_pkg::ST_ALIGN |=> step_r == `SBSC_STEP_FIRST)
      else $error("step moved during alignment");
   a_align_exit: assert property (
      (mode_r == sbsc_pkg::ST_ALIGN && align_timing_input && run)
      |=> mode_r == sbsc_pkg::ST_FORCED)
      else $error("alignment did not end at half reference");
   a_startup_duty: assert property (
      (mode_r == sbsc_pkg::ST_ALIGN || mode_r == sbsc_pkg::ST_FORCED)
      |-> duty == softstart_ramp_input)
      else $error("startup duty not from ramp");
   a_sense_duty: assert property (
      mode_r == sbsc_pkg::ST_SENSE |-> duty == speed_command_input)
      else $error("sensorless duty not from speed command");
   a_sense_entry: assert property (
      (mode_r == sbsc_pkg::ST_SENSE && $past(mode_r) == sbsc_pkg::ST_FORCED)
      |-> $past(zc) && $past(ivl_r) < $past(step_len))
      else $error("sensorless entered without fast edge");
   a_forced_steady: assert property (
      (mode_r == sbsc_pkg::ST_FORCED && !step_en) |=> $stable(step_r))
      else $error("forced step moved without divider pulse");
   a_forced_lead: assert property (
      mode_r != sbsc_pkg::ST_SENSE |-> eff_lead == `SBSC_LEAD_ZERO)
      else $error("lead applied outside sensorless mode");
   a_idle_off: assert property (
      mode_r == sbsc_pkg::ST_IDLE |=> gate_out == '0)
      else $error("gates driven while idle");
   a_apb_wait: assert property (
      (psel && !penable) ##1 (psel && penable) |-> pready)
      else $error("access phase not answered");

   c_forced: cover property (mode_r == sbsc_pkg::ST_ALIGN ##1 mode_r == sbsc_pkg::ST_FORCED);
   c_sense:  cover property (mode_r == sbsc_pkg::ST_FORCED ##1 mode_r == sbsc_pkg::ST_SENSE);
   c_step:   cover property (mode_r == sbsc_pkg::ST_SENSE && advance);
   c_err:    cover property (pslverr);
endmodule

/* test/sbsc_motor_model.sv */
// Behavioural power stage and motor: back-EMF comparators and alignment timing
`timescale 1ns/1ps
module sbsc_motor_model (
   input  wire logic        pclk,
   input  wire logic        spin,
   input  wire logic [15:0] period,
   input  wire logic        align_go,
   output logic             position_cmp_pos,
   output logic             position_cmp_neg,
   output logic             align_timing_input
);
   logic [15:0] cnt_r;

   initial begin
      cnt_r              = 16'h0000;
      position_cmp_pos   = 1'b0;
      position_cmp_neg   = 1'b1;
      align_timing_input = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Threshold result is a clean synchronous level, as the front end would give
   always @(posedge pclk) begin
      align_timing_input <= align_go;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One zero crossing per period; a long period models a slow rotor
   always @(posedge pclk) begin
      if (!spin) begin
         cnt_r <= 16'h0000;
      end else if (cnt_r + 16'h0001 >= period) begin
         cnt_r            <= 16'h0000;
         position_cmp_pos <= ~position_cmp_pos;
         position_cmp_neg <= position_cmp_pos;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end
endmodule

/* test/sbsc_top_tb.sv */
// Self-checking bench of the startup controller: straps, startup, PWM and APB
`timescale 1ns/1ps
`include "sbsc_consts.svh"
`define SBSC_CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module sbsc_top_tb;
   localparam int BASE = 16;
   logic                 pclk     = 1'b0;
   logic                 presetn  = 1'b0;
   logic [11:0]          paddr    = 12'h000;
   logic                 psel     = 1'b0;
   logic                 penable  = 1'b0;
   logic                 pwrite   = 1'b0;
   logic [31:0]          pwdata   = 32'h0000_0000;
   logic [1:0]           fst      = 2'h0;
   logic                 pwm_sel  = 1'b0;
   logic [1:0]           lead     = 2'h3;
   logic [6:0]           ramp     = 7'h00;
   logic [6:0]           speed    = 7'h00;
   logic                 spin     = 1'b0;
   logic                 align_go = 1'b0;
   logic [15:0]          period   = 16'h0010;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   logic                 pos;
   logic                 neg;
   logic                 align_in;
   sbsc_pkg::sbsc_gate_t gate_out;
   logic [31:0]          rd;
   logic                 err;
   int                   failures  = 0;
   int                   cmp_count = 0;
   int                   cyc       = 0;
   int                   seed      = 32'h7D9FD2B1;
   int                   on;
   int                   rises;
   int                   len;
   int                   t;

   sbsc_top #(.STEP_W(20), .STEP_BASE(BASE)) dut_u (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .forced_rate_sel_hi(fst[1]), .forced_rate_sel_lo(fst[0]), .pwm_rate_sel(pwm_sel),
      .lead_angle_sel_hi(lead[1]), .lead_angle_sel_lo(lead[0]),
      .position_cmp_pos(pos), .position_cmp_neg(neg), .align_timing_input(align_in),
      .softstart_ramp_input(ramp), .speed_command_input(speed), .gate_out(gate_out));

   sbsc_motor_model motor_u (
      .pclk(pclk), .spin(spin), .period(period), .align_go(align_go),
      .position_cmp_pos(pos), .position_cmp_neg(neg), .align_timing_input(align_in));

   always #25 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      if (failures == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Ceiling well above the longest strap setting's full pass
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         wrap_up();
      end
   end

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Exactly 512 clocks sampled, so any PWM phase gives whole periods
   task automatic pwm_meas();
      logic prev;
      logic cur;
      on = 0;
      rises = 0;
      @(negedge pclk);
      prev = |gate_out.hi;
      repeat (512) begin
         @(negedge pclk);
         cur = |gate_out.hi;
         on += int'(cur);
         rises += int'(cur & ~prev);
         prev = cur;
      end
      @(posedge pclk);
   endtask

   // Low side is not chopped, so its changes mark commutation steps cleanly
   task automatic wait_lo();
      logic [2:0] l0;
      @(negedge pclk);
      l0 = gate_out.lo;
      t = 0;
      while (gate_out.lo === l0 && t < 2000) begin
         @(negedge pclk);
         t++;
      end
      @(posedge pclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `SBSC_ADDR_CTRL, 32'h0);
      `SBSC_CHK("ctrl reset", 32'h0, rd)
      apb(1'b0, `SBSC_ADDR_STATUS, 32'h0);
      `SBSC_CHK("status reset", 32'h0, rd)
      apb(1'b0, 12'h00C, 32'h0);
      `SBSC_CHK("unmapped err", 1'b1, err)
      `SBSC_CHK("unmapped data", 32'h0, rd)
      apb(1'b1, `SBSC_ADDR_INTERVAL, 32'hFFFF_FFFF);
      `SBSC_CHK("ro write err", 1'b0, err)
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `SBSC_ADDR_CTRL, 32'h0);
         fst     <= i[1:0];
         pwm_sel <= i[0];
         lead    <= 2'(3 - i);
         ramp    <= 7'(1 + {$random(seed)} % 126);
         speed   <= 7'(1 + {$random(seed)} % 126);
         len = BASE << (3 - i);
         period  <= 16'(len);
         repeat (4) @(posedge pclk);
         apb(1'b0, `SBSC_ADDR_STATUS, 32'h0);
         `SBSC_CHK("idle mode", 2'h0, rd[1:0])
         apb(1'b1, `SBSC_ADDR_CTRL, 32'hFFFF_FFFF);
         apb(1'b0, `SBSC_ADDR_CTRL, 32'h0);
         `SBSC_CHK("ctrl run", 32'h1, rd)
         apb(1'b0, `SBSC_ADDR_STATUS, 32'h0);
         `SBSC_CHK("align mode", 2'h1, rd[1:0])
         `SBSC_CHK("align lead", 2'h0, rd[6:5])
         `SBSC_CHK("align low side", 3'b010, gate_out.lo)
         pwm_meas();
         `SBSC_CHK("ramp duty", 4 * int'(ramp), on)
         `SBSC_CHK("pwm periods", (i[0] ? 4 : 2), rises)
         align_go <= 1'b1;
         repeat (4) @(posedge pclk);
         apb(1'b0, `SBSC_ADDR_STATUS, 32'h0);
         `SBSC_CHK("forced mode", 2'h2, rd[1:0])
         `SBSC_CHK("forced lead", 2'h0, rd[6:5])
         wait_lo();
         wait_lo();
         `SBSC_CHK("forced step", 2 * len, t + 1)
         // A rotor exactly at the forced rate is not yet faster than it
         spin <= 1'b1;
         repeat (4 * len) @(posedge pclk);
         apb(1'b0, `SBSC_ADDR_STATUS, 32'h0);
         `SBSC_CHK("equal rate mode", 2'h2, rd[1:0])
         period <= 16'(len / 2);
         repeat (8 * len) @(posedge pclk);
         apb(1'b0, `SBSC_ADDR_STATUS, 32'h0);
         `SBSC_CHK("sense mode", 2'h3, rd[1:0])
         `SBSC_CHK("sense lead", lead, rd[6:5])
         apb(1'b0, `SBSC_ADDR_INTERVAL, 32'h0);
         `SBSC_CHK("edge interval", 32'(len / 2), rd)
         spin <= 1'b0;
         repeat (4 * len + 64) @(posedge pclk);
         pwm_meas();
         `SBSC_CHK("speed duty", 4 * int'(speed), on)
         align_go <= 1'b0;
      end
      presetn <= 1'b0;
      @(posedge pclk);
      @(negedge pclk);
      `SBSC_CHK("gates in reset", 6'h00, gate_out)
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `SBSC_ADDR_STATUS, 32'h0);
      `SBSC_CHK("status after reset", 32'h0, rd)
      wrap_up();
   end
endmodule
